// [twi_defines.svh]
`ifndef TWI_DEFINES_SVH
`define TWI_DEFINES_SVH

// ==========================================================================
// Register byte addresses.
`define ADDR_STATUS1   12'h000
`define ADDR_STATUS2   12'h004
`define ADDR_CLKDIV    12'h008
`define ADDR_DATA      12'h00C
`define ADDR_OWNADDR   12'h010
`define ADDR_CTRL      12'h014
`define ADDR_IRQSTAT   12'h018
`define ADDR_IRQMASK   12'h01C

// ==========================================================================
// Primary status bit positions.
`define ST_HDR   6
`define ST_DIR   5
`define ST_BUSY  4
`define ST_BTF   3
`define ST_SLAVE_ADDR_MATCHED_FLAG  2
`define ST_MSL   0

// ==========================================================================
// Secondary status bit positions.
`define S2_ACKF  4
`define S2_ARBITRATION_LOST_FLAG  3
`define S2_BUS_ERROR_FLAG  2
`define S2_STOP  1
`define S2_SB    0

// ==========================================================================
// Control bit positions.
`define CT_PE     0
`define CT_ACK    1
`define CT_START  2
`define CT_STOP   3
`define CT_HEADER_SENT_FLAG  4
`define CT_GCEN   5
`define CT_HALT   6
`define CT_WAIT   7

// ==========================================================================
// Reset values.
`define RST_CLKDIV  8'h00
`define RST_DATA    8'h00
`define RST_OWN     8'h00
`define RST_CTRL    8'h00
`define RST_MASK    8'h00

// ==========================================================================
// Ten-bit header pattern and general call address.
`define HDR_PATTERN 5'h1E
`define GEN_CALL    8'h00

`endif

// [twi_pkg.sv]
package twi_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_XFER = 3'b011,
    ST_WAIT = 3'b010,
    ST_ACK  = 3'b110,
    ST_HOLD = 3'b111
  } link_state_e;
endpackage : twi_pkg

// [twi_edge_det.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Three-flop filter with rise and fall pulses for one bus line.
module twi_edge_det (
  input  wire logic core_clk,
  input  wire logic nrst,
  input  wire logic lineIn,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      s1_ff <= 1'b1;
      s2_ff <= 1'b1;
      s3_ff <= 1'b1;
    end else begin
      s1_ff <= lineIn;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end
  assign level = s2_ff;
  assign rise  = s2_ff & ~s3_ff;
  assign fall  = ~s2_ff & s3_ff;
endmodule : twi_edge_det
`default_nettype wire

// [twi_core.sv]
`timescale 1ns/1ps
`default_nettype none
`include "twi_defines.svh"
// What this block does
// - In wait mode the block keeps working and enabled events request wake-up.
// - In halt mode the byte engine, data and status flags freeze, the bus is ignored and no acknowledge.
// - Eight events each have their own enable bit; they wake from wait, not halt.
// - One interrupt line, raised only when enabled and global mask clear.
// - Header-sent sets after ten-bit header; cleared by status2 read then data write.
// - Direction reads 1 after transmit, 0 after receive; clears with byte-finished.
// - Busy sets on start, clears on stop or bus error.
// - Busy is not updated while the peripheral is off.
// - Byte-finished sets per good byte; cleared by status1 read then data access.
// - Transmit byte-finished sets after acknowledge clock; address only after acknowledge.
// - Receive byte-finished sets after driving acknowledge clock; cleared by data read.
// - Clock line is held low while byte-finished is set and halt is clear.
// - Address-matched sets on own or general call address; status1 read clears it.
// - Seven-bit divider sets clock rate and survives peripheral disable.
// - Writing data in transmit mode starts transmission automatically.
// - Receive first byte automatically; later bytes only after data read.
// - Slave by default; master only while it runs its own sequence.
// - Ten-bit slave compare includes header 11110xx0 and two top address bits.
module twi_core
  import twi_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        globalMask,
  input  wire logic        sclIn,
  output logic             sclOut,
  output logic             sclOe,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  output logic             irq,
  output logic             wakeReq
);
  // ========================================================================
  // Bus slave.
  logic        wrPend_ff;
  logic        rdPend_ff;
  logic [11:0] addr_ff;
  logic [31:0] rdata_ff;
  wire         take = hsel & hready & htrans[1];
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      wrPend_ff <= 1'b0;
      rdPend_ff <= 1'b0;
      addr_ff   <= 12'h000;
    end else begin
      wrPend_ff <= take & hwrite;
      rdPend_ff <= take & ~hwrite;
      addr_ff   <= take ? haddr : addr_ff;
    end
  end
  wire rdStat1 = take & ~hwrite & (haddr == `ADDR_STATUS1);
  wire rdStat2 = take & ~hwrite & (haddr == `ADDR_STATUS2);
  wire rdData  = take & ~hwrite & (haddr == `ADDR_DATA);
  wire wrData  = wrPend_ff & (addr_ff == `ADDR_DATA);
  wire wrDiv   = wrPend_ff & (addr_ff == `ADDR_CLKDIV);
  wire wrOwn   = wrPend_ff & (addr_ff == `ADDR_OWNADDR);
  wire wrCtrl  = wrPend_ff & (addr_ff == `ADDR_CTRL);
  wire wrIst   = wrPend_ff & (addr_ff == `ADDR_IRQSTAT);
  wire wrMask  = wrPend_ff & (addr_ff == `ADDR_IRQMASK);
  wire anyAcc  = take & (haddr[11:5] == 7'h00);

  // ========================================================================
  // Software registers.
  logic [7:0] div_ff;
  logic [7:0] own_ff;
  logic [7:0] ctrl_ff;
  logic [7:0] mask_ff;
  logic [7:0] data_ff;
  wire  pe     = ctrl_ff[`CT_PE];
  wire  halted = ctrl_ff[`CT_HALT];
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      div_ff  <= `RST_CLKDIV;
      own_ff  <= `RST_OWN;
      ctrl_ff <= `RST_CTRL;
      mask_ff <= `RST_MASK;
    end else begin
      div_ff  <= wrDiv ? {1'b0, hwdata[6:0]} : div_ff;
      own_ff  <= wrOwn ? hwdata[7:0] : own_ff;
      ctrl_ff <= wrCtrl ? hwdata[7:0] : ctrl_ff;
      mask_ff <= wrMask ? hwdata[7:0] : mask_ff;
    end
  end

  // ========================================================================
  // Line sensing and condition detection.
  logic sclLvl, sclRise, sclFall, sdaLvl, sdaRise, sdaFall;
  twi_edge_det u_scl (
    .core_clk (core_clk),
    .nrst     (nrst),
    .lineIn   (sclIn),
    .level    (sclLvl),
    .rise     (sclRise),
    .fall     (sclFall)
  );
  twi_edge_det u_sda (
    .core_clk (core_clk),
    .nrst     (nrst),
    .lineIn   (sdaIn),
    .level    (sdaLvl),
    .rise     (sdaRise),
    .fall     (sdaFall)
  );
  wire startSeen = sdaFall & sclLvl;
  wire stopSeen  = sdaRise & sclLvl;
  // Halt freezes the byte engine and status flags and ignores the bus.
  wire live      = pe & ~halted;

  // ========================================================================
  // Flags and two-step clear tracking.
  logic hdr_ff, dir_ff, busy_ff, btf_ff, slave_addr_matched_flag_ff, msl_ff;
  logic sb_ff, ackf_ff, arbitration_lost_flag_ff, bus_error_flag_ff, stop_detected_flag_ff;
  logic arm1_ff, arm2_ff;
  logic hit1_ff, hit2_ff;
  // The data access itself disarms, so a completed clear is kept for its data phase.
  wire  dataTake = take & (haddr == `ADDR_DATA);
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      arm1_ff <= 1'b0;
      arm2_ff <= 1'b0;
      hit1_ff <= 1'b0;
      hit2_ff <= 1'b0;
    end else begin
      if (anyAcc) begin
        arm1_ff <= rdStat1;
        arm2_ff <= rdStat2;
      end
      hit1_ff <= arm1_ff & dataTake;
      hit2_ff <= arm2_ff & dataTake & hwrite;
    end
  end
  wire clrBtf = hit1_ff & (wrPend_ff | rdPend_ff);
  wire clrHdr = hit2_ff & wrData;

  // ========================================================================
  // Byte engine.
  link_state_e st_ff;
  logic [3:0]  bit_ff;
  logic [7:0]  sh_ff;
  logic        isAddr_ff;
  logic        tx_ff;
  logic        sdaDrv_ff;
  logic [7:0]  cnt_ff;
  logic        sclGen_ff;
  wire  rxDone  = (st_ff == ST_XFER) & sclRise & (bit_ff == 4'd7);
  wire  [7:0] rxByte = {sh_ff[6:0], sdaLvl};
  wire  tenHdr  = rxByte[7:3] == `HDR_PATTERN;
  wire  addrHit = ctrl_ff[`CT_HEADER_SENT_FLAG] ? (tenHdr & ~rxByte[0] & (rxByte[2:1] == own_ff[1:0]))
                  : (rxByte[7:1] == own_ff[7:1]) |
                    (ctrl_ff[`CT_GCEN] & (rxByte == `GEN_CALL));
  wire  ackClk  = (st_ff == ST_ACK) & sclFall;
  wire  setBtf  = ackClk & ~isAddr_ff & (tx_ff | ctrl_ff[`CT_ACK]);
  logic addrHitLatch_ff;
  wire  setAdsl = ackClk & isAddr_ff & ~msl_ff & addrHitLatch_ff;
  wire  stretch = btf_ff | slave_addr_matched_flag_ff;
  wire  hdrEv   = msl_ff & isAddr_ff & ackClk & ctrl_ff[`CT_HEADER_SENT_FLAG];
  wire  sbEv    = live & ctrl_ff[`CT_START] & ~busy_ff & ~msl_ff;
  wire  ackfEv  = ackClk & tx_ff & sdaLvl;
  wire  arloEv  = msl_ff & (st_ff == ST_XFER) & tx_ff & sclRise & ~sdaDrv_ff & ~sdaLvl;
  // A condition during the first clock of a byte is legal; later it is misplaced.
  wire  berrEv  = (startSeen | stopSeen) & (st_ff == ST_XFER) & (bit_ff > 4'd1);
  wire  stopEv  = stopSeen & ~msl_ff & busy_ff;
  always_ff @(posedge core_clk) begin
    if (!nrst | ~pe) begin
      st_ff           <= ST_IDLE;
      bit_ff          <= 4'd0;
      sh_ff           <= 8'h00;
      isAddr_ff       <= 1'b0;
      tx_ff           <= 1'b0;
      sdaDrv_ff       <= 1'b0;
      addrHitLatch_ff <= 1'b0;
      data_ff         <= `RST_DATA;
    end else if (live) begin
      data_ff <= wrData ? hwdata[7:0] : data_ff;
      case (st_ff)
        ST_IDLE: begin
          if (startSeen) begin
            st_ff     <= ST_ADDR;
            isAddr_ff <= 1'b1;
            bit_ff    <= 4'd0;
          end
        end
        ST_ADDR: st_ff <= ST_XFER;
        ST_XFER: begin
          if (sclRise) begin
            sh_ff  <= rxByte;
            bit_ff <= bit_ff + 4'd1;
          end
          if (sclFall & tx_ff) begin
            sdaDrv_ff <= ~sh_ff[7];
          end
          if (rxDone) begin
            st_ff           <= ST_WAIT;
            addrHitLatch_ff <= addrHit;
            if (!tx_ff) begin
              data_ff <= rxByte;
            end
          end
        end
        ST_ACK: begin
          if (ackClk) begin
            st_ff     <= (isAddr_ff & ~addrHitLatch_ff) ? ST_IDLE : ST_HOLD;
            tx_ff     <= isAddr_ff ? sh_ff[0] : tx_ff;
            isAddr_ff <= 1'b0;
            sdaDrv_ff <= 1'b0;
          end
        end
        ST_HOLD: begin
          // Next byte waits for software to service the flags.
          if (!stretch) begin
            st_ff  <= ST_XFER;
            bit_ff <= 4'd0;
            sh_ff  <= data_ff;
            sdaDrv_ff <= tx_ff & ~data_ff[7];
          end
        end
        ST_WAIT: begin
          // Acknowledge only what we are part of, once the eighth clock is low,
          // so the data line never moves while the clock is high.
          if (sclFall) begin
            st_ff     <= ST_ACK;
            sdaDrv_ff <= ~tx_ff & ctrl_ff[`CT_ACK] & (~isAddr_ff | addrHitLatch_ff);
          end
        end
        default: st_ff <= ST_IDLE;
      endcase
      if (stopSeen) begin
        st_ff <= ST_IDLE;
      end
    end
  end

  // ========================================================================
  // Status flag updates; set wins over clear.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      hdr_ff   <= 1'b0;
      dir_ff   <= 1'b0;
      busy_ff  <= 1'b0;
      btf_ff   <= 1'b0;
      slave_addr_matched_flag_ff  <= 1'b0;
      msl_ff   <= 1'b0;
      sb_ff    <= 1'b0;
      ackf_ff  <= 1'b0;
      arbitration_lost_flag_ff  <= 1'b0;
      bus_error_flag_ff  <= 1'b0;
      stop_detected_flag_ff <= 1'b0;
    end else if (!pe) begin
      hdr_ff  <= 1'b0;
      dir_ff  <= 1'b0;
      btf_ff  <= 1'b0;
      slave_addr_matched_flag_ff <= 1'b0;
      msl_ff  <= 1'b0;
      sb_ff   <= 1'b0;
      ackf_ff <= 1'b0;
      arbitration_lost_flag_ff <= 1'b0;
      bus_error_flag_ff <= 1'b0;
      stop_detected_flag_ff <= 1'b0;
      busy_ff <= busy_ff;
    end else if (live) begin
      busy_ff  <= startSeen | (busy_ff & ~stopSeen & ~berrEv);
      btf_ff   <= setBtf | (btf_ff & ~clrBtf);
      dir_ff   <= setBtf ? tx_ff
                  : (dir_ff & ~clrBtf & ~stopSeen & ~arloEv);
      slave_addr_matched_flag_ff  <= setAdsl | (slave_addr_matched_flag_ff & ~rdStat1);
      hdr_ff   <= hdrEv | (hdr_ff & ~clrHdr);
      msl_ff   <= sbEv | (msl_ff & ~stopSeen & ~arloEv);
      sb_ff    <= sbEv | (sb_ff & ~(clrBtf & wrData));
      ackf_ff  <= ackfEv | (ackf_ff & ~rdStat2);
      arbitration_lost_flag_ff  <= arloEv | (arbitration_lost_flag_ff & ~rdStat2);
      bus_error_flag_ff  <= berrEv | (bus_error_flag_ff & ~rdStat2);
      stop_detected_flag_ff <= stopEv | (stop_detected_flag_ff & ~rdStat2);
    end
  end
  // ========================================================================
  // Master clock generator and line drivers.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cnt_ff    <= 8'h00;
      sclGen_ff <= 1'b0;
    end else if (msl_ff & live & ~stretch) begin
      cnt_ff    <= (cnt_ff >= div_ff) ? 8'h00 : cnt_ff + 8'h01;
      sclGen_ff <= (cnt_ff >= div_ff) ? ~sclGen_ff : sclGen_ff;
    end
  end
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      sclOut     <= 1'b0;
      sclOe      <= 1'b1;
      sdaOut     <= 1'b0;
      sdaOe      <= 1'b1;
    end else begin
      sclOe      <= ~(live & (stretch | (msl_ff & sclGen_ff)));
      sdaOe      <= ~(live & sdaDrv_ff);
      sclOut     <= 1'b0;
      sdaOut     <= 1'b0;
    end
  end

  // ========================================================================
  // Interrupt status, mask and request.
  logic [7:0] ist_ff;
  wire  [7:0] evVec = {berrEv, arloEv, stopEv, ackfEv, sbEv, setAdsl, setBtf, hdrEv};
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ist_ff  <= 8'h00;
      irq     <= 1'b0;
      wakeReq <= 1'b0;
    end else begin
      ist_ff  <= (live ? evVec : 8'h00) | (ist_ff & ~(wrIst ? hwdata[7:0] : 8'h00));
      irq     <= ~globalMask & |(ist_ff & mask_ff);
      wakeReq <= ctrl_ff[`CT_WAIT] & |(ist_ff & mask_ff);
    end
  end

  // ========================================================================
  // Read data.
  wire [7:0] stat1 = {1'b0, hdr_ff, dir_ff, busy_ff, btf_ff, slave_addr_matched_flag_ff, 1'b0, msl_ff};
  wire [7:0] stat2 = {3'b000, ackf_ff, arbitration_lost_flag_ff, bus_error_flag_ff, stop_detected_flag_ff, sb_ff};
  wire [7:0] rsel  = (haddr == `ADDR_STATUS1) ? stat1 :
                     (haddr == `ADDR_STATUS2) ? stat2 :
                     (haddr == `ADDR_CLKDIV)  ? div_ff :
                     (haddr == `ADDR_DATA)    ? data_ff :
                     (haddr == `ADDR_OWNADDR) ? own_ff :
                     (haddr == `ADDR_CTRL)    ? ctrl_ff :
                     (haddr == `ADDR_IRQSTAT) ? ist_ff :
                     (haddr == `ADDR_IRQMASK) ? mask_ff : 8'h00;
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rdata_ff  <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      rdata_ff  <= (take & ~hwrite) ? {24'h000000, rsel} : rdata_ff;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end
  assign hrdata = rdata_ff;
  wire unusedSz = |hsize;
endmodule : twi_core
`default_nettype wire

// [twi_bus_checker.sv]
`timescale 1ns/1ps
`default_nettype none
`include "twi_defines.svh"
// ==========================================================================
// Port-level checks for the two-wire bus block.
module twi_bus_checker (
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic        hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        globalMask,
  input wire logic        sclOut,
  input wire logic        sclOe,
  input wire logic        sdaOut,
  input wire logic        sdaOe,
  input wire logic        irq,
  input wire logic        wakeReq
);
  wire logic        busTaken = hsel && htrans[1] && hready;
  logic             wrPh_ff;
  logic [11:0]      wrAddr_ff;
  logic [6:0]       div_ff;
  logic             pe_ff;
  logic             halt_ff;
  logic             wait_ff;
  // Mirror of divider and control writes, so a check knows the mode in force.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      wrPh_ff   <= 1'b0;
      wrAddr_ff <= 12'h000;
      div_ff    <= 7'h00;
      pe_ff     <= 1'b0;
      halt_ff   <= 1'b0;
      wait_ff   <= 1'b0;
    end else begin
      wrPh_ff   <= busTaken && hwrite;
      wrAddr_ff <= haddr;
      if (wrPh_ff && wrAddr_ff == `ADDR_CLKDIV) div_ff <= hwdata[6:0];
      if (wrPh_ff && wrAddr_ff == `ADDR_CTRL) begin
        pe_ff   <= hwdata[`CT_PE];
        halt_ff <= hwdata[`CT_HALT];
        wait_ff <= hwdata[`CT_WAIT];
      end
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence rdAt(logic [11:0] a);
    busTaken && !hwrite && haddr == a;
  endsequence
  // Two samples are needed because the mode bit lands one edge before the pins.
  sequence twice(logic b);
    b ##1 b;
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_pins_open: assert property (!sclOut && !sdaOut)
    else $error("bus line driven high");
  a_irq_gmask: assert property (irq |-> !$past(globalMask))
    else $error("interrupt while globally masked");
  a_stretch_bus: assert property ($rose(sclOe) |->
    $past(busTaken) || $past(busTaken, 2) || $past(busTaken, 3))
    else $error("clock released without register access");
  a_unmapped_zero: assert property (busTaken && !hwrite && haddr >= 12'h020 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_div_kept: assert property (rdAt(`ADDR_CLKDIV) |=> hrdata[6:0] == div_ff)
    else $error("divider read differs from last write");
  a_halt_silent: assert property (twice(halt_ff) |-> sdaOe)
    else $error("data line driven in halt");
  a_off_quiet: assert property (twice(!pe_ff) |-> sclOe && sdaOe)
    else $error("bus line driven while off");
  a_wake_gate: assert property (twice(!wait_ff) |-> !wakeReq)
    else $error("wake request outside wait");
endmodule : twi_bus_checker
`default_nettype wire

// [twi_partner.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Behavioural master on the far side of the two-wire bus.
module twi_partner (
  input  wire logic core_clk,
  input  wire logic scl,
  input  wire logic sda,
  output logic      sclDrv,
  output logic      sdaDrv
);
  localparam int HALF = 8;
  int stalls = 0;
  initial begin
    sclDrv = 1'b1;
    sdaDrv = 1'b1;
  end
  task automatic pause();
    repeat (HALF) @(posedge core_clk);
  endtask : pause
  // The slave may hold the clock; the wait is bounded so a stuck line shows up.
  task automatic rise();
    int n;
    n = 0;
    sclDrv <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (scl !== 1'b1 && n < 4000);
    if (n >= 4000) stalls++;
  endtask : rise
  task automatic start();
    sdaDrv <= 1'b0;
    pause();
    sclDrv <= 1'b0;
    pause();
  endtask : start
  task automatic stop();
    sdaDrv <= 1'b0;
    pause();
    rise();
    pause();
    sdaDrv <= 1'b1;
    pause();
  endtask : stop
  // Data only changes a half period after the clock falls, never near its rise.
  task automatic send(input logic [7:0] b, output logic ack);
    logic [8:0] w;
    w = {b, 1'b1};
    for (int i = 8; i >= 0; i--) begin
      sdaDrv <= w[i];
      pause();
      rise();
      pause();
      if (i == 0) ack = !sda;
      sclDrv <= 1'b0;
      pause();
    end
  endtask : send
endmodule : twi_partner
`default_nettype wire

// [two_wire_bus_status_and_data_test.sv]
`timescale 1ns/1ps
`default_nettype none
`include "twi_defines.svh"
module two_wire_bus_status_and_data_test;
  typedef struct {logic [31:0] e; logic [31:0] m; logic [11:0] a;} note_s;
  logic        core_clk   = 1'b0;
  logic        nrst       = 1'b0;
  logic        hsel       = 1'b0;
  logic [11:0] haddr      = 12'h000;
  logic [1:0]  htrans     = 2'b00;
  logic        hwrite     = 1'b0;
  logic [31:0] hwdata     = 32'h0;
  logic        globalMask = 1'b1;
  logic        rdPh       = 1'b0;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, sclOut, sclOe, sdaOut, sdaOe, irq, wakeReq;
  logic        sclDrv, sdaDrv, ack;
  logic [7:0]  own, d;
  logic [6:0]  div;
  int          bad_count  = 0;
  int          n_compared = 0;
  note_s       nt;
  note_s       q[$];
  logic [11:0] regs[9] = '{`ADDR_STATUS1, `ADDR_STATUS2, `ADDR_CLKDIV, `ADDR_DATA,
    `ADDR_OWNADDR, `ADDR_CTRL, `ADDR_IRQSTAT, `ADDR_IRQMASK, 12'h020};
  wire logic   scl = sclDrv & (sclOe | sclOut);
  wire logic   sda = sdaDrv & (sdaOe | sdaOut);
  always #20 core_clk = ~core_clk;
  twi_core twi_core_i (.core_clk(core_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .globalMask(globalMask),
    .sclIn(scl), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sda), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .irq(irq), .wakeReq(wakeReq));
  twi_partner twi_partner_i (.core_clk(core_clk), .scl(scl), .sda(sda), .sclDrv(sclDrv),
    .sdaDrv(sdaDrv));
  task automatic end_sim();
    bad_count += twi_partner_i.stalls;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g,
                     input logic [31:0] m);
    n_compared++;
    if (((g ^ e) & m) !== 32'h0) begin
      bad_count++;
      $display("CHECK FAILED %s exp %h seen %h", nm, e & m, g);
    end
  endtask : cmp
  task automatic pin(input string nm, input logic e, input logic g);
    cmp(nm, {31'h0, e}, {31'h0, g}, 32'h1);
  endtask : pin
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick
  // One idle edge after each transfer keeps register updates apart from the next access.
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] dat);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do begin
      @(posedge core_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    htrans <= 2'b00;
    hwdata <= dat;
    do begin
      @(posedge core_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    if (n >= 40) begin
      bad_count++;
      end_sim();
    end
    @(posedge core_clk);
  endtask : xfer
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
    q.push_back('{e, m, a});
    xfer(a, 1'b0, 32'h0);
  endtask : rd
  task automatic wr(input logic [11:0] a, input logic [31:0] dat);
    xfer(a, 1'b1, dat);
  endtask : wr
  always @(posedge core_clk) begin
    if (rdPh && q.size() > 0) begin
      nt = q.pop_front();
      cmp($sformatf("reg %h", nt.a), nt.e, hrdata, nt.m);
    end
    rdPh <= nrst && hsel && htrans[1] && hreadyout && !hwrite;
  end
  initial begin
    repeat (100000) @(posedge core_clk);
    bad_count++;
    end_sim();
  end
  initial begin
    void'($urandom(51));
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    foreach (regs[i]) rd(regs[i], 32'h0, 32'hFFFFFFFF);
    div = 7'($urandom);
    wr(`ADDR_CLKDIV, {25'h0, div});
    wr(`ADDR_CTRL, 32'h1);
    wr(`ADDR_CTRL, 32'h0);
    rd(`ADDR_CLKDIV, {25'h0, div}, 32'h7F);
    twi_partner_i.start();
    rd(`ADDR_STATUS1, 32'h0, 32'h10);
    twi_partner_i.stop();
    own = {7'($urandom_range(119, 8)), 1'b0};
    wr(`ADDR_OWNADDR, {24'h0, own});
    wr(`ADDR_IRQMASK, 32'hFF);
    wr(`ADDR_CTRL, 32'h3);
    globalMask <= 1'b0;
    twi_partner_i.start();
    rd(`ADDR_STATUS1, 32'h10, 32'h10);
    twi_partner_i.send(own, ack);
    tick(8);
    pin("ack", 1'b1, ack);
    pin("sclOe", 1'b0, sclOe);
    pin("irq", 1'b1, irq);
    rd(`ADDR_IRQSTAT, 32'h4, 32'h4);
    rd(`ADDR_STATUS1, 32'h14, 32'h14);
    tick(2);
    pin("sclOe", 1'b1, sclOe);
    rd(`ADDR_STATUS1, 32'h0, 32'h4);
    wr(`ADDR_IRQSTAT, 32'hFF);
    tick(2);
    pin("irq", 1'b0, irq);
    d = 8'($urandom);
    twi_partner_i.send(d, ack);
    tick(8);
    pin("ack", 1'b1, ack);
    pin("sclOe", 1'b0, sclOe);
    pin("irq", 1'b1, irq);
    globalMask <= 1'b1;
    tick(3);
    pin("irq", 1'b0, irq);
    globalMask <= 1'b0;
    rd(`ADDR_STATUS1, 32'h8, 32'h28);
    rd(`ADDR_DATA, {24'h0, d}, 32'hFF);
    rd(`ADDR_STATUS1, 32'h0, 32'h8);
    wr(`ADDR_CTRL, 32'h83);
    wr(`ADDR_IRQSTAT, 32'hFF);
    d = 8'($urandom);
    twi_partner_i.send(d, ack);
    tick(8);
    pin("wakeReq", 1'b1, wakeReq);
    rd(`ADDR_STATUS1, 32'h8, 32'h8);
    rd(`ADDR_CTRL, 32'h83, 32'hFF);
    rd(`ADDR_DATA, {24'h0, d}, 32'hFF);
    rd(`ADDR_STATUS1, 32'h8, 32'h8);
    rd(`ADDR_DATA, {24'h0, d}, 32'hFF);
    rd(`ADDR_STATUS1, 32'h0, 32'h8);
    wr(`ADDR_CTRL, 32'h3);
    wr(`ADDR_IRQSTAT, 32'hFF);
    twi_partner_i.stop();
    rd(`ADDR_STATUS1, 32'h0, 32'h30);
    rd(`ADDR_STATUS2, 32'h2, 32'h2);
    wr(`ADDR_CTRL, 32'h43);
    twi_partner_i.start();
    twi_partner_i.send(own, ack);
    pin("ack", 1'b0, ack);
    twi_partner_i.stop();
    wr(`ADDR_CTRL, 32'h3);
    twi_partner_i.start();
    twi_partner_i.send(own, ack);
    tick(8);
    wr(`ADDR_CTRL, 32'h0);
    tick(2);
    pin("sclOe", 1'b1, sclOe);
    rd(`ADDR_STATUS1, 32'h0, 32'h2C);
    twi_partner_i.stop();
    end_sim();
  end
endmodule : two_wire_bus_status_and_data_test
bind twi_core twi_bus_checker twi_bus_checker_i (.core_clk(core_clk), .nrst(nrst),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .globalMask(globalMask), .sclOut(sclOut), .sclOe(sclOe), .sdaOut(sdaOut),
  .sdaOe(sdaOe), .irq(irq), .wakeReq(wakeReq));
`default_nettype wire
